// ===== inc/debug_break_pkg.sv
// package: break control layout, debug register offsets and carrier types
package debug_break_pkg;

    // ==================================================================
    // widths
    // ==================================================================
    localparam int ADDR_W = 24;
    localparam int BYTE_W = 8;
    localparam int NUM_SETS = 4;

    // ==================================================================
    // debug register offsets (write-only space)
    // ==================================================================
    localparam logic [7:0] MATCH_FIRST_OFFSET = 8'h00;
    localparam logic [7:0] MATCH_LAST_OFFSET = 8'h0E;
    localparam logic [7:0] BREAK_CONTROL_OFFSET = 8'h10;
    localparam logic [1:0] MATCH_LOW_BYTE = 2'h0;
    localparam logic [1:0] MATCH_HIGH_BYTE = 2'h1;
    localparam logic [1:0] MATCH_UPPER_BYTE = 2'h2;

    // ==================================================================
    // reset values
    // ==================================================================
    localparam logic [7:0] BREAK_CONTROL_RESET = 8'h00;
    localparam logic [23:0] MATCH_RESET = 24'h000000;

    // ==================================================================
    // carrier types
    // ==================================================================
    // field order follows bit 7 down to bit 0 of break_control
    typedef struct packed {
        logic       next_instr_break;
        logic [3:0] match_set_enable;
        logic       set1_page_match;
        logic       set0_page_match;
        logic       single_step;
    } break_control_t;

    typedef struct packed {
        logic       wr_en;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_write_t;

    typedef struct packed {
        logic        fetch;
        logic        boundary;
        logic        long_address_mode;
        logic [7:0]  memory_base_byte;
        logic [23:0] addr;
    } cpu_bus_t;

endpackage

// ===== hdl/address_match_set.sv
// one address-match comparator with optional low-byte ignore
`timescale 1ns/1ps
module address_match_set #(
    parameter int ADDR_W = 24
) (
    input  wire logic [ADDR_W-1:0] match_addr,
    input  wire logic [ADDR_W-1:0] cpu_addr,
    input  wire logic              enable,
    input  wire logic              page_match,
    output wire logic              hit
);
    wire logic upper_equal;
    wire logic low_equal;

    assign upper_equal = (cpu_addr[ADDR_W-1:8] == match_addr[ADDR_W-1:8]);
    assign low_equal   = (cpu_addr[7:0] == match_addr[7:0]);
    // page mode drops the low byte so the whole 256-byte page hits
    assign hit = enable & upper_equal & (page_match | low_equal);
endmodule // address_match_set

// ===== hdl/debug_breakpoint_control.sv
// breakpoint, forced break and single-step control of the serial debug interface
`timescale 1ns/1ps
// What this block does
// - break when enabled set equals instruction address
// - breaks only at instruction boundaries, deferred
// - address match sets next instruction break bit
// - break held until host clears bit
// - host writing one forces next break
// - clock high, data low at reset arms
// - bits six to three enable sets three-zero
// - set one full compare when not paged
// - set one paged compares address bits 23-8
// - bit one pages set zero likewise
// - bit zero breaks after every instruction
// - compare long address or base byte concatenation
// - match break puts CPU into debug mode
module debug_breakpoint_control #(
    parameter int ADDR_W   = debug_break_pkg::ADDR_W,
    parameter int NUM_SETS = debug_break_pkg::NUM_SETS
) (
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  wire debug_break_pkg::reg_write_t reg_write,
    input  wire debug_break_pkg::cpu_bus_t   cpu_bus,
    input  wire logic                       debug_link_clock_pin,
    input  wire logic                       debug_link_data_pin,
    output logic                            cpu_break,
    output debug_break_pkg::break_control_t break_control_state
);
    // ==================================================================
    // compared address
    // ==================================================================
    function automatic logic [ADDR_W-1:0] compare_address(
        input debug_break_pkg::cpu_bus_t bus
    );
        if (bus.long_address_mode)
            compare_address = bus.addr;
        else
            compare_address = {bus.memory_base_byte, bus.addr[15:0]};
    endfunction

    // ==================================================================
    // registers
    // ==================================================================
    // halted is the only state that stops the core
    typedef enum logic [0:0] {
        RUNNING = 1'b0,
        HALTED  = 1'b1
    } halt_state_t;

    debug_break_pkg::break_control_t break_control;
    debug_break_pkg::break_control_t next_break_control;
    logic [ADDR_W-1:0]               match_addr [NUM_SETS];
    logic                            match_pending;
    halt_state_t                     halt_state;
    halt_state_t                     next_halt_state;
    wire logic                       break_active;
    logic                            strap_window;
    logic [1:0]                      clock_pin_sync;
    logic [1:0]                      data_pin_sync;

    // ==================================================================
    // write decode
    // ==================================================================
    wire logic        ctl_write;
    wire logic        match_write;
    wire logic [1:0]  match_set_sel;
    wire logic [1:0]  match_byte_sel;
    wire logic [7:0]  write_data;
    wire debug_break_pkg::break_control_t write_ctl;

    assign write_data     = reg_write.data;
    assign write_ctl      = debug_break_pkg::break_control_t'(write_data);
    assign ctl_write      = reg_write.wr_en & (reg_write.addr == debug_break_pkg::BREAK_CONTROL_OFFSET);
    assign match_write    = reg_write.wr_en
                          & (reg_write.addr >= debug_break_pkg::MATCH_FIRST_OFFSET)
                          & (reg_write.addr <= debug_break_pkg::MATCH_LAST_OFFSET);
    assign match_set_sel  = reg_write.addr[3:2];
    assign match_byte_sel = reg_write.addr[1:0];

    // ==================================================================
    // match units
    // ==================================================================
    wire logic [ADDR_W-1:0]   cmp_addr;
    wire logic [NUM_SETS-1:0] set_hit;
    wire logic [NUM_SETS-1:0] set_page;
    wire logic                any_hit;

    assign cmp_addr = compare_address(cpu_bus);
    // only sets 0 and 1 have a page mode
    assign set_page = {{(NUM_SETS-2){1'b0}},
                       break_control.set1_page_match,
                       break_control.set0_page_match};

    genvar g;
    generate
        for (g = 0; g < NUM_SETS; g++) begin : g_set
            address_match_set #(
                .ADDR_W     (ADDR_W)
            ) u_match (
                .match_addr (match_addr[g]),
                .cpu_addr   (cmp_addr),
                .enable     (break_control.match_set_enable[g]),
                .page_match (set_page[g]),
                .hit        (set_hit[g])
            );

            always_ff @(posedge clk) begin
                if (!resetn) begin
                    match_addr[g] <= debug_break_pkg::MATCH_RESET;
                end else if (match_write && match_set_sel == 2'(g)) begin
                    case (match_byte_sel)
                        debug_break_pkg::MATCH_LOW_BYTE:   match_addr[g][7:0]   <= write_data;
                        debug_break_pkg::MATCH_HIGH_BYTE:  match_addr[g][15:8]  <= write_data;
                        debug_break_pkg::MATCH_UPPER_BYTE: match_addr[g][23:16] <= write_data;
                        default:                           match_addr[g]        <= match_addr[g];
                    endcase
                end
            end
        end
    endgenerate

    assign any_hit = (|set_hit) & cpu_bus.fetch & ~break_active;

    // ==================================================================
    // break decision at boundary
    // ==================================================================
    wire logic strap_arm;
    wire logic boundary;
    wire logic take_break;
    wire logic hw_set_next;
    wire logic release_write;

    // synchroniser outputs only; first stages stay unread
    assign strap_arm   = strap_window & clock_pin_sync[1] & ~data_pin_sync[1];
    assign boundary    = cpu_bus.boundary & ~break_active;
    assign hw_set_next = boundary & (match_pending | any_hit | break_control.single_step);
    assign take_break  = boundary & (hw_set_next | break_control.next_instr_break);
    assign release_write = ctl_write & ~write_ctl.next_instr_break;

    // ==================================================================
    // pin synchronisers
    // ==================================================================
    always_ff @(posedge clk) begin
        clock_pin_sync <= {clock_pin_sync[0], debug_link_clock_pin};
        data_pin_sync  <= {data_pin_sync[0], debug_link_data_pin};
    end

    // ==================================================================
    // control state
    // ==================================================================
    always_comb begin
        next_break_control = break_control;
        if (ctl_write) begin
            next_break_control = write_ctl;
        end
        // hardware set wins over a host clear in the same cycle
        if (hw_set_next || strap_arm) begin
            next_break_control.next_instr_break = 1'b1;
        end
    end

    // strap looked at in the first cycle after release only
    always_ff @(posedge clk) begin
        if (!resetn) begin
            strap_window <= 1'b1;
        end else begin
            strap_window <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            break_control <= debug_break_pkg::BREAK_CONTROL_RESET;
        end else begin
            break_control <= next_break_control;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            match_pending <= 1'b0;
        end else if (boundary) begin
            match_pending <= 1'b0;
        end else if (any_hit) begin
            match_pending <= 1'b1;
        end
    end

    // ==================================================================
    // halt state machine
    // ==================================================================
    // a release while running is a no-op, so the host may clear freely
    always_comb begin
        next_halt_state = halt_state;
        case (halt_state)
            RUNNING: begin
                if (take_break) begin
                    next_halt_state = HALTED;
                end
            end
            HALTED: begin
                if (release_write) begin
                    next_halt_state = RUNNING;
                end
            end
            default: begin
                next_halt_state = RUNNING;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            halt_state <= RUNNING;
        end else begin
            halt_state <= next_halt_state;
        end
    end

    assign break_active        = (halt_state == HALTED);
    assign cpu_break           = break_active;
    assign break_control_state = break_control;
endmodule // debug_breakpoint_control

// ===== hdl/unused_placeholder_none.sv
// intentionally empty file with no module
`timescale 1ns/1ps

// ===== tb/debug_breakpoint_control_sva.sv
// checker: break and break_control relations seen at the top module ports
`timescale 1ns/1ps
module debug_breakpoint_control_sva (
    input wire logic                            clk,
    input wire logic                            resetn,
    input wire debug_break_pkg::reg_write_t     reg_write,
    input wire debug_break_pkg::cpu_bus_t       cpu_bus,
    input wire logic                            debug_link_clock_pin,
    input wire logic                            debug_link_data_pin,
    input wire logic                            cpu_break,
    input wire debug_break_pkg::break_control_t break_control_state
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire logic take = cpu_bus.boundary && !cpu_break;
    wire logic ctl  = reg_write.wr_en && reg_write.addr == 8'h10;
    wire logic clr  = ctl && !reg_write.data[7];
    // ==================================================================
    // assertions
    // ==================================================================
    AST_RESET_CLEAR: assert property (disable iff (1'b0)
        !resetn |=> !cpu_break && break_control_state == 8'h00) else $error("not clear");
    AST_BOUNDARY_ONLY: assert property ($rose(cpu_break) |-> $past(cpu_bus.boundary))
        else $error("break off boundary");
    AST_FORCED: assert property (take && break_control_state.next_instr_break
        |=> cpu_break) else $error("forced break missed");
    AST_STEP: assert property (take && break_control_state.single_step
        |=> cpu_break && break_control_state.next_instr_break) else $error("step missed");
    AST_HOLD: assert property (cpu_break && !clr |=> cpu_break)
        else $error("break dropped");
    AST_RELEASE: assert property (cpu_break && clr |=> !cpu_break)
        else $error("break not released");
    AST_WRITE_COPY: assert property (ctl && !take && $past(resetn)
        |=> break_control_state == $past(reg_write.data)) else $error("bad copy");
    AST_STATE_KEPT: assert property (!ctl && !take && $past(resetn) && $past(resetn, 2)
        && $past(resetn, 3) |=> $stable(break_control_state)) else $error("state moved");
    COV_BREAK: cover property ($rose(cpu_break));
    COV_RELEASE: cover property (cpu_break && clr);
    COV_STEP: cover property (take && break_control_state.single_step);
endmodule // debug_breakpoint_control_sva

bind debug_breakpoint_control debug_breakpoint_control_sva i_sva (
    .clk(clk), .resetn(resetn), .reg_write(reg_write), .cpu_bus(cpu_bus),
    .debug_link_clock_pin(debug_link_clock_pin), .debug_link_data_pin(debug_link_data_pin),
    .cpu_break(cpu_break), .break_control_state(break_control_state));

// ===== tb/debug_host_model.sv
// debug host model: register writes over the link and reset strap levels
`timescale 1ns/1ps
module debug_host_model (
    input  wire logic                   clk,
    output debug_break_pkg::reg_write_t reg_write,
    output logic                        debug_link_clock_pin,
    output logic                        debug_link_data_pin
);
    initial begin
        reg_write = '0;
        debug_link_clock_pin = 1'b0;
        debug_link_data_pin = 1'b1;
    end
    task automatic strap(input logic c, input logic d);
        debug_link_clock_pin = c;
        debug_link_data_pin = d;
    endtask
    // frame of 800 ns keeps the strobe just after a clk edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        repeat (2) begin
            #400 debug_link_clock_pin = ~debug_link_clock_pin;
        end
        reg_write = '{wr_en: 1'b1, addr: a, data: d};
        @(posedge clk);
        #1 reg_write.wr_en = 1'b0;
    endtask
endmodule // debug_host_model

// ===== tb/test_debug_breakpoint_control.sv
// testbench: reset strap, match sets, page match, stepping and forced breaks
`timescale 1ns/1ps
module test_debug_breakpoint_control;
    logic                            clk;
    logic                            resetn = 1'b0;
    logic                            cpu_break, clock_pin, data_pin;
    logic [23:0]                     a;
    debug_break_pkg::cpu_bus_t       cpu_bus = '0;
    debug_break_pkg::reg_write_t     reg_write;
    debug_break_pkg::break_control_t state;
    int                              n_errors = 0;
    int                              check_count = 0;
    debug_breakpoint_control i_dut (.clk(clk), .resetn(resetn), .reg_write(reg_write),
        .cpu_bus(cpu_bus), .debug_link_clock_pin(clock_pin), .debug_link_data_pin(data_pin),
        .cpu_break(cpu_break), .break_control_state(state));
    debug_host_model i_host (.clk(clk), .reg_write(reg_write),
        .debug_link_clock_pin(clock_pin), .debug_link_data_pin(data_pin));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ==================================================================
    // tasks
    // ==================================================================
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic do_reset(input logic c, input logic d);
        resetn = 1'b0;
        tick();
        i_host.strap(c, d);
        tick(11);
        resetn = 1'b1;
        tick(3);
    endtask
    // two-byte instruction whose second byte carries the address
    task automatic instr(input logic [23:0] ad, input logic lam, input logic exp);
        cpu_bus.long_address_mode = lam;
        cpu_bus.fetch = 1'b1;
        cpu_bus.addr = ad - 24'h1;
        tick();
        cpu_bus.addr = ad;
        tick();
        cpu_bus.fetch = 1'b0;
        check(8'(cpu_break), 8'h00);
        cpu_bus.boundary = 1'b1;
        tick();
        cpu_bus.boundary = 1'b0;
        tick();
        check(8'(cpu_break), 8'(exp));
    endtask
    task automatic release_break(input logic [7:0] d);
        i_host.wr(8'h10, d);
        tick();
        check(8'(cpu_break), 8'h00);
    endtask
    task automatic tally_and_finish();
        $display("TB: checks=%0d mismatches=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ==================================================================
    // sequence
    // ==================================================================
    initial begin
        do_reset(1'b1, 1'b0);
        check(state, 8'h80);
        instr(24'h000010, 1'b1, 1'b1);
        release_break(8'h00);
        do_reset(1'b0, 1'b0);
        check(state, 8'h00);
        $display("TB: reset strap done");
        for (int s = 0; s < 4; s++) begin
            a = 24'h120040 + 24'(s) * 24'h100;
            for (int b = 0; b < 3; b++) i_host.wr(8'(s * 4 + b), a[b*8+:8]);
            i_host.wr(8'h10, 8'h08 << s);
            instr(a, 1'b1, 1'b1);
            check(state, (8'h08 << s) | 8'h80);
            release_break(8'h08 << ((s + 1) % 4));
            instr(a, 1'b1, 1'b0);
        end
        $display("TB: match sets done");
        for (int s = 0; s < 2; s++) begin
            a = 24'h1200C0 + 24'(s) * 24'h100;
            i_host.wr(8'h10, 8'h08 << s);
            instr(a, 1'b1, 1'b0);
            i_host.wr(8'h10, (8'h08 << s) | (8'h02 << s));
            instr(a, 1'b1, 1'b1);
            release_break((8'h08 << s) | (8'h02 << s));
            check(state, (8'h08 << s) | (8'h02 << s));
        end
        i_host.wr(8'h11, 8'hFF);
        check(state, 8'h14);
        i_host.wr(8'h10, 8'h08);
        cpu_bus.memory_base_byte = 8'h12;
        instr(24'hAB0040, 1'b0, 1'b1);
        release_break(8'h00);
        $display("TB: page and base done");
        i_host.wr(8'h10, 8'h01);
        instr(24'h003000, 1'b1, 1'b1);
        check(state, 8'h81);
        release_break(8'h01);
        instr(24'h003000, 1'b1, 1'b1);
        release_break(8'h00);
        instr(24'h003000, 1'b1, 1'b0);
        i_host.wr(8'h10, 8'h80);
        instr(24'h004000, 1'b1, 1'b1);
        release_break(8'h00);
        $display("TB: step and forced done");
        tally_and_finish();
    end
    initial begin
        #2000000;
        n_errors++;
        tally_and_finish();
    end
endmodule // test_debug_breakpoint_control
